// [hdl/fic_checksum.v]
// Flash image checksum engine: sums a byte stream, adds masked config/id words.
// Assumes the reader streams bytes in order; config/id words come as the core reads them.
`include "fic_defs.vh"

module fic_checksum #(
  parameter DEPTH = `FIC_FIFO_DEPTH,
  parameter AW = `FIC_FIFO_AW
) (
  // Clock and reset
  input wire core_clk_in,
  input wire reset_n_in,
  // Request side
  input wire start_in,
  input wire mode_in,
  input wire [1:0] family_in,
  input wire code_protect_in,
  input wire [31:0] prog_len_in,
  input wire [31:0] boot_len_in,
  input wire [31:0] range_start_in,
  input wire [31:0] range_len_in,
  output reg busy_out,
  output reg done_out,
  output reg [31:0] result_out,
  output reg [31:0] rd_addr_out,
  // Config and identity words, core view
  input wire [31:0] config_word_zero_in,
  input wire [31:0] config_word_one_in,
  input wire [31:0] config_word_two_in,
  input wire [31:0] config_word_three_in,
  input wire [31:0] identity_word_in,
  // Byte stream from memory reader
  input wire byte_valid_in,
  input wire [7:0] byte_data_in,
  output wire byte_ready_out
);
  ////////////////////////////////////////////////////////////////////////
  // Sequencer states, one-hot
  localparam ST_IDLE = 4'b0001;
  localparam ST_SUM = 4'b0010;
  localparam ST_WORDS = 4'b0100;
  localparam ST_DONE = 4'b1000;

  reg [3:0] state_q;
  reg mode_q;
  reg [1:0] fam_q;
  reg [31:0] left_q;
  reg [31:0] skip_q;
  reg [31:0] acc_q;
  reg [31:0] addr_q;
  reg [2:0] word_q;
  // Masks for the family latched at start
  reg [31:0] m0;
  reg [31:0] m1;
  reg [31:0] m2;
  reg [31:0] m3;
  reg [31:0] mid;
  reg [31:0] word_sel;
  reg [31:0] masked;
  reg [31:0] job_len;
  reg [31:0] job_skip;

  // Byte buffer drain side
  wire f_valid;
  wire [7:0] f_data;
  // Pop only while bytes are still owed; surplus waits for the flush
  wire f_ready = (state_q == ST_SUM) && (left_q != 32'h0000_0000);
  // A taken start drops any bytes left over from the last job
  wire flush = start_in && !busy_out;

  ////////////////////////////////////////////////////////////////////////
  // Byte buffer between the reader and the adder
  fic_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_fifo (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .in_valid_in(byte_valid_in),
    .in_data_in(byte_data_in),
    .in_ready_out(byte_ready_out),
    .out_valid_out(f_valid),
    .out_data_out(f_data),
    .out_ready_in(f_ready),
    .flush_in(flush)
  );

  ////////////////////////////////////////////////////////////////////////
  // Mask selection
  always @* begin
    case (fam_q)
      `FIC_FAM_DUAL: begin
        m0 = `FIC_DUAL_M0;
        m1 = `FIC_DUAL_M1;
        m2 = `FIC_DUAL_M2;
        m3 = `FIC_DUAL_M3;
        mid = `FIC_DUAL_MID;
      end
      `FIC_FAM_SMALL: begin
        m0 = `FIC_SMALL_M0;
        m1 = `FIC_SMALL_M1;
        m2 = `FIC_SMALL_M2;
        m3 = `FIC_SMALL_M3;
        mid = `FIC_SMALL_MID;
      end
      default: begin
        // Unknown family: all bits implemented
        m0 = 32'hffff_ffff;
        m1 = 32'hffff_ffff;
        m2 = 32'hffff_ffff;
        m3 = 32'hffff_ffff;
        mid = 32'hffff_ffff;
      end
    endcase
  end

  always @* begin
    case (word_q)
      3'd0: word_sel = config_word_zero_in & m0;
      3'd1: word_sel = config_word_one_in & m1;
      3'd2: word_sel = config_word_two_in & m2;
      3'd3: word_sel = config_word_three_in & m3;
      3'd4: word_sel = identity_word_in & mid;
      default: word_sel = 32'h0000_0000;
    endcase
    // Four bytes peak at 0x3fc, so this add never wraps
    masked = {24'h00_0000, word_sel[7:0]} + {24'h00_0000, word_sel[15:8]}
      + {24'h00_0000, word_sel[23:16]} + {24'h00_0000, word_sel[31:24]};
  end

  ////////////////////////////////////////////////////////////////////////
  // Job bounds, taken from the request at start
  always @* begin
    if (mode_in == `FIC_MODE_RANGE) begin
      job_len = range_len_in;
      job_skip = 32'h0000_0000;
    end else begin
      // Boot length includes the sixteen config bytes at its end
      job_len = prog_len_in + boot_len_in;
      job_skip = `FIC_CFG_BYTES;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  wire take = f_valid && f_ready;
  // Tail of a full image holds the config words, summed masked instead
  wire in_cfg = (left_q <= skip_q);

  always @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      state_q <= ST_IDLE;
      mode_q <= `FIC_MODE_FULL;
      fam_q <= `FIC_FAM_DUAL;
      left_q <= 32'h0000_0000;
      skip_q <= 32'h0000_0000;
      acc_q <= `FIC_ACC_RESET;
      addr_q <= 32'h0000_0000;
      word_q <= 3'd0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      // Result clears too, so a read before any job sees zero
      result_out <= 32'h0000_0000;
      rd_addr_out <= 32'h0000_0000;
    end else begin
      done_out <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start_in) begin
            busy_out <= 1'b1;
            mode_q <= mode_in;
            fam_q <= family_in;
            acc_q <= `FIC_ACC_RESET;
            word_q <= 3'd0;
            addr_q <= range_start_in;
            left_q <= job_len;
            skip_q <= job_skip;
            state_q <= ST_SUM;
          end
        end
        ST_SUM: begin
          // Length reached: any surplus stays queued for the flush
          if (left_q == 32'h0000_0000) begin
            state_q <= (mode_q == `FIC_MODE_RANGE) ? ST_DONE : ST_WORDS;
          end else if (take) begin
            left_q <= left_q - 32'h0000_0001;
            addr_q <= addr_q + 32'h0000_0001;
            rd_addr_out <= addr_q;
            if (!in_cfg) begin
              // Unsigned byte add; the 32-bit total wraps by design
              acc_q <= acc_q + {24'h00_0000, f_data};
            end
          end
        end
        ST_WORDS: begin
          // One masked word per cycle: config zero to three, then identity
          acc_q <= acc_q + masked;
          if (word_q == 3'd4) begin
            state_q <= ST_DONE;
          end else begin
            word_q <= word_q + 3'd1;
          end
        end
        ST_DONE: begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
          state_q <= ST_IDLE;
          if (mode_q == `FIC_MODE_RANGE) begin
            // Range sum is handed back plain, not complemented
            result_out <= acc_q;
          end else if (code_protect_in) begin
            // Config words unreadable while protected
            result_out <= 32'h0000_0000;
          end else begin
            result_out <= (~acc_q) + 32'h0000_0001;
          end
        end
        default: begin
          // Lost one-hot code: recover to idle
          state_q <= ST_IDLE;
          busy_out <= 1'b0;
        end
      endcase
    end
  end
endmodule // fic_checksum

// [hdl/fic_defs.vh]
// Constants for the flash image checksum block.
// Assumes inclusion by bare name from hdl/ design files and the tb/ bench.
//
// Behaviour
// - The full-image result is the two's complement of the 32-bit total of all contributions; a range sum is returned plain.
// - Every program byte is added unsigned into a 32-bit accumulator that wraps.
// - Every boot byte is added unsigned, except the region holding the config words.
// - The last sixteen boot bytes are the four config words and skip the plain boot sum.
// - Each config word is ANDed with its mask and its four bytes are added.
// - The identity word is ANDed with its mask and its four bytes are added.
// - Config words are taken as the core reads them, not as raw stored bits.
// - Dual-panel family masks are 0x7fffffff, 0xffff0000 and 0x0fffffff for word 0, 3, id.
// - Small-pin family masks are 0x1100fc1f, 0x03dff7a7 and 0xf0000000 for words 0, 1, 3.
// - A mask has ones on implemented bits and zeros on unimplemented ones.
// - While code-protected a full-image job reports a checksum of zero; a range job still returns its plain sum.
// - A request carries a 32-bit start and 32-bit byte length; the answer is one word.
`ifndef FIC_DEFS_VH
`define FIC_DEFS_VH

`define FIC_FAM_DUAL 2'd0
`define FIC_FAM_SMALL 2'd1
`define FIC_FAM_NONE 2'd2

`define FIC_MODE_FULL 1'b0
`define FIC_MODE_RANGE 1'b1

`define FIC_CFG_BYTES 32'h0000_0010
`define FIC_ACC_RESET 32'h0000_0000

`define FIC_DUAL_M0 32'h7fff_ffff
`define FIC_DUAL_M1 32'hffff_ffff
`define FIC_DUAL_M2 32'hffff_ffff
`define FIC_DUAL_M3 32'hffff_0000
`define FIC_DUAL_MID 32'h0fff_ffff

`define FIC_SMALL_M0 32'h1100_fc1f
`define FIC_SMALL_M1 32'h03df_f7a7
`define FIC_SMALL_M2 32'h0007_0077
`define FIC_SMALL_M3 32'hf000_0000
`define FIC_SMALL_MID 32'h0fff_ffff

`define FIC_FIFO_DEPTH 16
`define FIC_FIFO_AW 4

`endif

// [hdl/fic_fifo.v]
// Synchronous flop FIFO for the byte stream.
// Assumes single clock, synchronous active-low reset.
module fic_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire core_clk_in,
  input wire reset_n_in,
  // Fill side
  input wire in_valid_in,
  input wire [WIDTH-1:0] in_data_in,
  output wire in_ready_out,
  // Drain side
  output wire out_valid_out,
  output wire [WIDTH-1:0] out_data_out,
  input wire out_ready_in,
  // Flush on new job
  input wire flush_in
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  reg [AW:0] cnt_d;
  // Ready is a flop so the reader never sees a combinational path
  reg ready_q;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;
  assign in_ready_out = ready_q;

  always @* begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end
  assign out_valid_out = (cnt_q != {(AW+1){1'b0}});
  assign out_data_out = mem_q[rd_q];

  always @(posedge core_clk_in) begin
    if (push) begin
      mem_q[wr_q] <= in_data_in;
    end
  end

  always @(posedge core_clk_in) begin
    if (!reset_n_in || flush_in) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      ready_q <= 1'b1;
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      cnt_q <= cnt_d;
      ready_q <= (cnt_d != DEPTH[AW:0]);
    end
  end
endmodule // fic_fifo

// [tb/fic_checker_assertions.sv]
// Handshake and result checks for the checksum engine.
// Assumes binding to the fic_checksum ports by name.
module fic_checker (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // Handshake
  input wire logic start_in,
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic [31:0] result_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_take;
    start_in && !busy_out;
  endsequence
  sequence s_quiet;
    !done_out [*6];
  endsequence
  AST_TAKE: assert property (s_take |=> busy_out) else $error("busy not raised");
  AST_MIN_LAT: assert property (s_take |=> s_quiet) else $error("done too early");
  AST_DONE_PULSE: assert property (done_out |=> !done_out) else $error("done too long");
  AST_DONE_IDLE: assert property (done_out |-> !busy_out) else $error("busy with done");
  AST_DONE_CAUSE: assert property (done_out |-> $past(busy_out)) else $error("done unasked");
  AST_BUSY_CAUSE: assert property ($rose(busy_out) |-> $past(start_in)) else $error("busy unasked");
  AST_BUSY_END: assert property ($fell(busy_out) |-> done_out) else $error("busy dropped");
  AST_RES_HOLD: assert property (!done_out |-> $stable(result_out)) else $error("result moved");
  AST_RESET: assert property (disable iff (1'b0) !reset_n_in |=> !busy_out && !done_out
    && result_out == 32'h0) else $error("reset state wrong");
endmodule // fic_checker

// [tb/fic_streamer.sv]
// Memory reader model: streams queued bytes with random stalls.
// Assumes the bench queues bytes only after a start is taken.
module fic_streamer (
  // Clock
  input wire logic core_clk_in,
  // Byte stream
  input wire logic byte_ready_in,
  output logic byte_valid_out,
  output logic [7:0] byte_data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] q[$];
  initial begin
    byte_valid_out = 1'b0;
    byte_data_out = 8'h5a;
  end
  // Offer held until taken; idle data toggles so stale bytes never pass
  always @(posedge core_clk_in) begin
    if (!byte_valid_out || byte_ready_in) begin
      if (byte_valid_out) begin
        void'(q.pop_front());
      end
      if (q.size() != 0 && $urandom_range(3) != 0) begin
        byte_valid_out <= 1'b1;
        byte_data_out <= q[0];
      end else begin
        byte_valid_out <= 1'b0;
        byte_data_out <= ~byte_data_out;
      end
    end
  end
endmodule // fic_streamer

// [tb/test_flash_image_checksum.sv]
// Self-checking bench for the checksum engine.
// Assumes fic_defs.vh on the include path.
`include "fic_defs.vh"
module test_flash_image_checksum;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_in, reset_n_in, start_in, mode_in, code_protect_in;
  logic busy_out, done_out, byte_valid_in, byte_ready_out;
  logic [1:0] family_in;
  logic [31:0] prog_len_in, boot_len_in, range_start_in, result_out;
  logic [31:0] range_len_in, rd_addr_out;
  logic [31:0] cw[5];
  logic [7:0] byte_data_in;
  int errors, comparisons, cycles;
  always #25 core_clk_in = ~core_clk_in;
  fic_checksum u_fic_checksum (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
    .start_in(start_in), .mode_in(mode_in), .family_in(family_in),
    .code_protect_in(code_protect_in), .prog_len_in(prog_len_in), .boot_len_in(boot_len_in),
    .range_start_in(range_start_in), .range_len_in(range_len_in), .busy_out(busy_out),
    .done_out(done_out), .result_out(result_out), .rd_addr_out(rd_addr_out),
    .config_word_zero_in(cw[0]), .config_word_one_in(cw[1]), .config_word_two_in(cw[2]),
    .config_word_three_in(cw[3]), .identity_word_in(cw[4]), .byte_valid_in(byte_valid_in),
    .byte_data_in(byte_data_in), .byte_ready_out(byte_ready_out));
  fic_streamer u_fic_streamer (.core_clk_in(core_clk_in), .byte_ready_in(byte_ready_out),
    .byte_valid_out(byte_valid_in), .byte_data_out(byte_data_in));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] bsum(input logic [31:0] w);
    return 32'h0 + w[7:0] + w[15:8] + w[23:16] + w[31:24];
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic close_out;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // One job; a second start inside busy must be ignored
  task automatic run(input logic m, input logic [1:0] f, input logic p, input int np,
    input int nb);
    logic [31:0] e, d[5], s[5];
    logic [7:0] b;
    int w;
    d = '{`FIC_DUAL_M0, `FIC_DUAL_M1, `FIC_DUAL_M2, `FIC_DUAL_M3, `FIC_DUAL_MID};
    s = '{`FIC_SMALL_M0, `FIC_SMALL_M1, `FIC_SMALL_M2, `FIC_SMALL_M3, `FIC_SMALL_MID};
    e = 32'h0;
    start_in = 1'b1;
    mode_in = m;
    family_in = f;
    code_protect_in = p;
    prog_len_in = np;
    boot_len_in = nb;
    range_start_in = $urandom;
    range_len_in = m ? np : $urandom;
    foreach (cw[i]) cw[i] = $urandom;
    @(negedge core_clk_in);
    start_in = 1'b0;
    for (int i = 0; i < np + nb; i++) begin
      b = $urandom;
      u_fic_streamer.q.push_back(b);
      if (m || i < np + nb - 16) e += b;
    end
    foreach (cw[i]) if (!m) e += bsum(cw[i] & (f == 0 ? d[i] : f == 1 ? s[i] : '1));
    if (!m) e = p ? 32'h0 : -e;
    @(negedge core_clk_in);
    start_in = 1'b1;
    @(negedge core_clk_in);
    start_in = 1'b0;
    w = 0;
    while (done_out !== 1'b1 && w < 500) begin
      @(negedge core_clk_in);
      w++;
    end
    chk("done", 32'h1, done_out);
    chk("result", e, result_out);
    chk("last address", range_start_in + np + nb - 1, rd_addr_out);
  endtask
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      close_out;
    end
  end
  initial begin
    core_clk_in = 1'b0;
    reset_n_in = 1'b0;
    start_in = 1'b0;
    mode_in = 1'b0;
    family_in = 2'h0;
    code_protect_in = 1'b0;
    prog_len_in = 32'h0;
    boot_len_in = 32'h0;
    range_start_in = 32'h0;
    range_len_in = 32'h0;
    foreach (cw[i]) cw[i] = 32'h0;
    errors = 0;
    comparisons = 0;
    cycles = 0;
    void'($urandom(32'h28b6de48));
    repeat (6) @(negedge core_clk_in);
    reset_n_in = 1'b1;
    chk("reset result", 32'h0, result_out);
    for (int f = 0; f < 3; f++) run(0, f, 0, $urandom_range(40, 1), $urandom_range(40, 16));
    run(0, 1, 0, 0, 16);
    run(0, 0, 1, 9, 20);
    run(1, 2, 0, 33, 0);
    run(0, 0, 0, 5, 17);
    close_out;
  end
endmodule // test_flash_image_checksum
bind fic_checksum fic_checker u_fic_checker (.core_clk_in(core_clk_in),
  .reset_n_in(reset_n_in), .start_in(start_in), .busy_out(busy_out),
  .done_out(done_out), .result_out(result_out));
